// file: hrap_pkg.sv
// package: shared constants and carriers for the host register access port
package hrap_pkg;
   localparam int DW = 8;
   localparam int AW = 4;
   localparam int NEVT = 4;
   // register indices
   localparam logic [AW-1:0] A_GMASK = 4'h0;
   localparam logic [AW-1:0] A_FR_STAT = 4'h1;
   localparam logic [AW-1:0] A_FR_MASK = 4'h2;
   localparam logic [AW-1:0] A_LIU_STAT = 4'h3;
   localparam logic [AW-1:0] A_LIU_MASK = 4'h4;
   localparam logic [AW-1:0] A_BERT_STAT = 4'h5;
   localparam logic [AW-1:0] A_BERT_MASK = 4'h6;
   localparam logic [AW-1:0] A_INT_SUM = 4'h7;
   localparam logic [AW-1:0] A_SCR_BASE = 4'h8;
   localparam int NSCR = 8;
   // global mask bit positions, 1 blocks the group
   localparam int GM_FR = 0;
   localparam int GM_LIU = 1;
   localparam int GM_BERT = 2;
   localparam logic [DW-1:0] MASK_RST = 8'hff;
   localparam logic [DW-1:0] ZERO_B = 8'h00;
   localparam logic [DW-1:0] ALL_B = 8'hff;
   localparam logic [NEVT-1:0] EVT_ZERO = 4'h0;

   typedef struct packed {
      logic chip_select_n;
      logic read_strobe_n;   // doubles as data_strobe_n
      logic write_strobe_n;  // doubles as read_write_select
      logic [AW-1:0] addr;
   } hrap_bus_s;

   typedef struct packed {
      logic [NEVT-1:0] framer;
      logic [NEVT-1:0] liu;
      logic [NEVT-1:0] bert;
   } hrap_evt_s;
endpackage : hrap_pkg

// file: hrap_irq_tree.sv
// sticky interrupt status per group with a per-bit event mask
module hrap_irq_tree (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [hrap_pkg::NEVT-1:0] evt,
   input wire logic [hrap_pkg::NEVT-1:0] clr,
   input wire logic [hrap_pkg::NEVT-1:0] mask,
   output logic [hrap_pkg::NEVT-1:0] stat_reg,
   output logic pend
);
   import hrap_pkg::*;

   logic [NEVT-1:0] stat_next;

   // set wins over a write-one clear in the same cycle
   assign stat_next = (stat_reg & ~clr) | evt;
   assign pend = |(stat_reg & ~mask);

   always_ff @(posedge mclk) begin
      if (rst) begin
         stat_reg <= EVT_ZERO;
      end else begin
         stat_reg <= stat_next;
      end
   end

   a_sticky_set: assert property (@(posedge mclk) disable iff (rst)
      evt[0] |=> stat_reg[0]) else $error("event bit not captured");
endmodule : hrap_irq_tree

// file: hrap_port.sv
// parallel host register access port with interrupt output
// Operation
// - strobes count only while chip_select_n is low.
// - read: drive addressed register on data bus while read strobe and select low.
// - write: capture bus data on rising edge of write strobe under select.
// - bus_style 1: read pin is data strobe, write pin is read/write select.
// - serial_mode 1: data bit 0 carries serial slave data output.
// - irq_n asserts when any unmasked event is pending.
// - irq_n released (three-stated) once no unmasked event is pending, whether the events are cleared or masked.
// - masks at global, framer, line interface and bit-error test levels.
// - data bus is eight bits wide, both directions.
module hrap_port (
   input wire logic mclk,
   input wire logic rst,
   input wire hrap_pkg::hrap_bus_s bus,
   input wire logic bus_style,
   input wire logic serial_mode,
   input wire logic [hrap_pkg::DW-1:0] data_in,
   output logic [hrap_pkg::DW-1:0] data_out,
   output logic [hrap_pkg::DW-1:0] data_oe,
   input wire logic serial_sdo,
   input wire logic serial_sdo_oe,
   input wire hrap_pkg::hrap_evt_s evt,
   output logic irq_n_out,
   output logic irq_n_oe
);
   import hrap_pkg::*;

   // -----------------------------------------------------------------
   // strobe decode
   // -----------------------------------------------------------------
   logic strobe_n_reg;
   logic rw_reg;
   logic cs_reg;
   wire par_en = ~serial_mode;
   wire cs_ok = ~bus.chip_select_n & par_en;
   // style 0: separate strobes; style 1: data strobe plus direction
   wire rd_cond = bus_style ?
      (~bus.read_strobe_n & bus.write_strobe_n) :
      ~bus.read_strobe_n;
   wire rd_active = cs_ok & rd_cond;
   wire wr_strobe_n = bus_style ? bus.read_strobe_n : bus.write_strobe_n;
   wire wr_dir = bus_style ? ~bus.write_strobe_n : 1'b1;
   // write taken when the strobe rises while select stayed low
   wire wr_pulse = cs_reg & ~strobe_n_reg & rw_reg & wr_strobe_n
      & cs_ok;

   always_ff @(posedge mclk) begin
      if (rst) begin
         strobe_n_reg <= 1'b1;
         rw_reg <= 1'b0;
         cs_reg <= 1'b0;
      end else begin
         strobe_n_reg <= wr_strobe_n;
         rw_reg <= wr_dir;
         cs_reg <= cs_ok;
      end
   end

   // -----------------------------------------------------------------
   // register file
   // -----------------------------------------------------------------
   logic [DW-1:0] gmask_reg;
   logic [NEVT-1:0] fr_mask_reg, liu_mask_reg, bert_mask_reg;
   logic [DW-1:0] scr_reg [NSCR];
   logic [NEVT-1:0] fr_stat, liu_stat, bert_stat;
   logic fr_pend, liu_pend, bert_pend;
   logic irq_reg;
   logic [DW-1:0] rdata_reg;
   logic [DW-1:0] rdata_next;

   function automatic logic hit(input logic [AW-1:0] a,
                                input logic [AW-1:0] r);
      hit = (a == r);
   endfunction : hit

   function automatic logic [NEVT-1:0] clr_of(input logic w,
                                              input logic [AW-1:0] a,
                                              input logic [AW-1:0] r,
                                              input logic [DW-1:0] d);
      clr_of = (w && a == r) ? d[NEVT-1:0] : EVT_ZERO;
   endfunction : clr_of

   wire [NEVT-1:0] fr_clr = clr_of(wr_pulse, bus.addr, A_FR_STAT, data_in);
   wire [NEVT-1:0] liu_clr = clr_of(wr_pulse, bus.addr, A_LIU_STAT, data_in);
   wire [NEVT-1:0] bert_clr = clr_of(wr_pulse, bus.addr, A_BERT_STAT,
                                     data_in);
   wire scr_sel = bus.addr[AW-1];
   wire [AW-2:0] scr_idx = bus.addr[AW-2:0];
   wire [DW-1:0] int_sum = {5'h00, bert_pend, liu_pend, fr_pend};

   always_ff @(posedge mclk) begin
      if (rst) begin
         gmask_reg <= MASK_RST;
         fr_mask_reg <= MASK_RST[NEVT-1:0];
         liu_mask_reg <= MASK_RST[NEVT-1:0];
         bert_mask_reg <= MASK_RST[NEVT-1:0];
      end else if (wr_pulse) begin
         if (hit(bus.addr, A_GMASK)) gmask_reg <= data_in;
         if (hit(bus.addr, A_FR_MASK)) fr_mask_reg <= data_in[NEVT-1:0];
         if (hit(bus.addr, A_LIU_MASK)) liu_mask_reg <= data_in[NEVT-1:0];
         if (hit(bus.addr, A_BERT_MASK)) bert_mask_reg <= data_in[NEVT-1:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int i = 0; i < NSCR; i++) scr_reg[i] <= ZERO_B;
      end else if (wr_pulse && scr_sel) begin
         scr_reg[scr_idx] <= data_in;
      end
   end

   // -----------------------------------------------------------------
   // read path
   // -----------------------------------------------------------------
   always_comb begin
      rdata_next = ZERO_B;
      case (bus.addr)
         A_GMASK: rdata_next = gmask_reg;
         A_FR_STAT: rdata_next = {4'h0, fr_stat};
         A_FR_MASK: rdata_next = {4'h0, fr_mask_reg};
         A_LIU_STAT: rdata_next = {4'h0, liu_stat};
         A_LIU_MASK: rdata_next = {4'h0, liu_mask_reg};
         A_BERT_STAT: rdata_next = {4'h0, bert_stat};
         A_BERT_MASK: rdata_next = {4'h0, bert_mask_reg};
         A_INT_SUM: rdata_next = int_sum;
         default: rdata_next = scr_reg[scr_idx];
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) rdata_reg <= ZERO_B;
      else rdata_reg <= rdata_next;
   end

   assign data_out = serial_mode ? {rdata_reg[DW-1:1], serial_sdo} :
      rdata_reg;
   assign data_oe = serial_mode ? {7'h00, serial_sdo_oe} :
      (rd_active ? ALL_B : ZERO_B);

   // -----------------------------------------------------------------
   // interrupt tree
   // -----------------------------------------------------------------
   hrap_irq_tree u_fr (.mclk(mclk), .rst(rst), .evt(evt.framer),
      .clr(fr_clr), .mask(fr_mask_reg), .stat_reg(fr_stat), .pend(fr_pend));
   hrap_irq_tree u_liu (.mclk(mclk), .rst(rst), .evt(evt.liu),
      .clr(liu_clr), .mask(liu_mask_reg), .stat_reg(liu_stat),
      .pend(liu_pend));
   hrap_irq_tree u_bert (.mclk(mclk), .rst(rst), .evt(evt.bert),
      .clr(bert_clr), .mask(bert_mask_reg), .stat_reg(bert_stat),
      .pend(bert_pend));

   wire pending = (fr_pend & ~gmask_reg[GM_FR])
      | (liu_pend & ~gmask_reg[GM_LIU])
      | (bert_pend & ~gmask_reg[GM_BERT]);

   always_ff @(posedge mclk) begin
      if (rst) irq_reg <= 1'b0;
      else irq_reg <= pending;
   end

   assign irq_n_out = 1'b0;
   assign irq_n_oe = irq_reg;

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   // write strobe sampled low with write direction under select
   sequence s_wr_low;
      ~bus.chip_select_n && ~wr_strobe_n && wr_dir && par_en;
   endsequence

   // strobe sampled high again, select still low
   sequence s_wr_rise;
      ~bus.chip_select_n && wr_strobe_n && par_en;
   endsequence

   // complete write: low sample followed by the rising sample
   sequence s_wr_done;
      s_wr_low ##1 s_wr_rise;
   endsequence

   a_cs_gate: assert property (@(posedge mclk) disable iff (rst)
      (bus.chip_select_n && !serial_mode) |-> data_oe == ZERO_B)
      else $error("bus driven without chip select");
   a_read_drive: assert property (@(posedge mclk) disable iff (rst)
      (rd_active && $stable(bus.addr) && !$past(rst)) |-> data_oe == ALL_B
      && data_out == $past(rdata_next))
      else $error("read data not driven");
   a_write_cap: assert property (@(posedge mclk) disable iff (rst)
      s_wr_done ##0 (bus.addr == A_GMASK) |=> gmask_reg == $past(data_in))
      else $error("write not captured on strobe rise");
   a_style_ds: assert property (@(posedge mclk) disable iff (rst)
      (bus_style && cs_ok && !bus.read_strobe_n && !bus.write_strobe_n)
      |-> data_oe == ZERO_B) else $error("write cycle drove bus");
   a_serial_d0: assert property (@(posedge mclk) disable iff (rst)
      serial_mode |-> data_oe[0] == serial_sdo_oe
      && data_out[0] == serial_sdo && data_oe[DW-1:1] == 7'h00)
      else $error("serial output not on bit 0");
   a_irq_raise: assert property (@(posedge mclk) disable iff (rst)
      pending |=> irq_n_oe && !irq_n_out)
      else $error("interrupt not asserted");
   a_irq_release: assert property (@(posedge mclk) disable iff (rst)
      (!pending ##1 !pending) |-> !irq_n_oe)
      else $error("interrupt held without pending event");
   a_mask_block: assert property (@(posedge mclk) disable iff (rst)
      (gmask_reg[2:0] == 3'h7) |=> !irq_n_oe)
      else $error("global mask did not block interrupt");
   a_scr_write: assert property (@(posedge mclk) disable iff (rst)
      s_wr_done ##0 scr_sel |=> scr_reg[$past(scr_idx)] == $past(data_in))
      else $error("scratch byte not captured");
   a_mask_write: assert property (@(posedge mclk) disable iff (rst)
      s_wr_done ##0 (bus.addr == A_FR_MASK)
      |=> fr_mask_reg == $past(data_in[NEVT-1:0]))
      else $error("framer mask not captured");
   a_wr_refused: assert property (@(posedge mclk) disable iff (rst)
      (bus.chip_select_n || serial_mode) |=> $stable(gmask_reg))
      else $error("write taken without select");
   a_stat_clear: assert property (@(posedge mclk) disable iff (rst)
      s_wr_done ##0 (bus.addr == A_FR_STAT && data_in[0] && !evt.framer[0])
      |=> !fr_stat[0]) else $error("status not cleared by write");
   a_rd_style: assert property (@(posedge mclk) disable iff (rst)
      (bus_style && cs_ok && !bus.read_strobe_n && bus.write_strobe_n)
      |-> data_oe == ALL_B) else $error("style read not driven");
   a_oe_idle: assert property (@(posedge mclk) disable iff (rst)
      (!rd_active && !serial_mode) |-> data_oe == ZERO_B)
      else $error("bus driven outside a read");
   a_no_pend: assert property (@(posedge mclk) disable iff (rst)
      (!fr_pend && !liu_pend && !bert_pend) |=> !irq_n_oe)
      else $error("interrupt without pending group");
   a_irq_hold: assert property (@(posedge mclk) disable iff (rst)
      (irq_n_oe && pending) |=> irq_n_oe)
      else $error("interrupt released while pending");
endmodule : hrap_port

// file: hrap_host_model.sv
// host processor model driving the parallel register bus
module hrap_host_model
   import hrap_pkg::*;
(
   input wire logic mclk,
   input wire logic bus_style,
   output hrap_pkg::hrap_bus_s bus,
   output logic [hrap_pkg::DW-1:0] data_in,
   input wire logic [hrap_pkg::DW-1:0] data_out,
   input wire logic [hrap_pkg::DW-1:0] data_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------
   // idle bus: strobes high, data not held
   // ----------------------------------------
   task automatic release_bus;
      bus = '{1'b1, 1'b1, 1'b1, bus.addr};
      data_in = ~data_in;
   endtask : release_bus
   initial begin
      bus = '{1'b1, 1'b1, 1'b1, 4'h0};
      data_in = 8'h00;
   end
   // one byte access, write strobe low one cycle, read strobe low two cycles, then released
   task automatic access(input logic wr, input logic cs_n,
      input logic [AW-1:0] a, input logic [DW-1:0] d,
      output logic [DW-1:0] q, output logic [DW-1:0] oe);
      @(negedge mclk);
      bus.chip_select_n = cs_n;
      bus.addr = a;
      data_in = wr ? d : ~data_in;
      bus.write_strobe_n = ~wr;
      bus.read_strobe_n = bus_style ? 1'b0 : wr;
      @(negedge mclk);
      q = data_out;
      oe = data_oe;
      if (wr && bus_style) begin
         bus.read_strobe_n = 1'b1;
      end else if (wr) begin
         bus.write_strobe_n = 1'b1;
      end
      @(negedge mclk);
      release_bus();
   endtask : access
endmodule : hrap_host_model

// file: hrap_port_test.sv
// self-checking bench for the host register access port
module hrap_port_test;
   timeunit 1ns;
   timeprecision 1ns;
   import hrap_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic bus_style = 1'b0;
   logic serial_mode = 1'b0;
   logic serial_sdo = 1'b0;
   logic serial_sdo_oe = 1'b0;
   hrap_evt_s evt = '0;
   hrap_bus_s bus;
   logic [DW-1:0] data_in, data_out, data_oe, q, oe;
   logic irq_n_out, irq_n_oe;
   int failures = 0;
   int n_compared = 0;
   int cycles = 0;
   // rows: address, write data, expected read back
   localparam logic [19:0] ROWS [6] = '{20'h8a5a5, 20'hf5a5a, 20'h00505,
      20'h2f303, 20'h6ff0f, 20'h7ff00};
   always #25 mclk = ~mclk;
   hrap_port i_hrap_port (.mclk(mclk), .rst(rst), .bus(bus),
      .bus_style(bus_style), .serial_mode(serial_mode), .data_in(data_in),
      .data_out(data_out), .data_oe(data_oe), .serial_sdo(serial_sdo),
      .serial_sdo_oe(serial_sdo_oe), .evt(evt), .irq_n_out(irq_n_out),
      .irq_n_oe(irq_n_oe));
   hrap_host_model i_hrap_host_model (.mclk(mclk), .bus_style(bus_style),
      .bus(bus), .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic check(input string name, input logic [DW-1:0] seen,
      input logic [DW-1:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      i_hrap_host_model.access(1'b1, 1'b0, a, d, q, oe);
      repeat (2) @(negedge mclk);
   endtask : wr
   task automatic rd(input logic [AW-1:0] a);
      i_hrap_host_model.access(1'b0, 1'b0, a, 8'h00, q, oe);
   endtask : rd
   task automatic pulse(input logic [3*NEVT-1:0] f);
      @(negedge mclk);
      evt = f;
      @(negedge mclk);
      evt = '0;
      repeat (3) @(negedge mclk);
   endtask : pulse
   task automatic finish_test;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : finish_test
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         $display("ERROR timeout expected end seen hang");
         finish_test();
      end
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge mclk);
      @(negedge mclk);
      rst = 1'b0;
      check("oe_rst", data_oe, 8'h00);
      check("irq_rst", {7'h0, irq_n_oe}, 8'h00);
      check("dout_rst", data_out, 8'h00);
      rd(A_FR_MASK);
      check("mask_rst", q, 8'h0f);
      check("rd_oe", oe, 8'hff);
      for (int i = 0; i < 6; i++) begin
         bus_style = i[0];
         wr(ROWS[i][19:16], ROWS[i][15:8]);
         rd(ROWS[i][19:16]);
         check("row", q, ROWS[i][7:0]);
      end
      bus_style = 1'b0;
      i_hrap_host_model.access(1'b1, 1'b1, 4'h9, 8'h3c, q, oe);
      i_hrap_host_model.access(1'b0, 1'b1, 4'h9, 8'h00, q, oe);
      check("oe_nosel", oe, 8'h00);
      rd(4'h9);
      check("wr_nosel", q, 8'h00);
      wr(A_GMASK, 8'h00);
      wr(A_FR_MASK, 8'h0e);
      pulse(12'h200);
      check("irq_masked", {7'h0, irq_n_oe}, 8'h00);
      rd(A_FR_STAT);
      check("fr_stat", q, 8'h02);
      pulse(12'h100);
      check("irq_on", {7'h0, irq_n_oe}, 8'h01);
      check("irq_level", {7'h0, irq_n_out}, 8'h00);
      wr(A_GMASK, 8'h01);
      check("irq_glob", {7'h0, irq_n_oe}, 8'h00);
      wr(A_GMASK, 8'h00);
      check("irq_back", {7'h0, irq_n_oe}, 8'h01);
      wr(A_GMASK, 8'h07);
      check("irq_all", {7'h0, irq_n_oe}, 8'h00);
      wr(A_GMASK, 8'h00);
      wr(A_FR_STAT, 8'h01);
      check("irq_clr", {7'h0, irq_n_oe}, 8'h00);
      wr(A_LIU_MASK, 8'h0b);
      pulse(12'h040);
      check("irq_liu", {7'h0, irq_n_oe}, 8'h01);
      rd(A_INT_SUM);
      check("sum_liu", q, 8'h02);
      wr(A_LIU_STAT, 8'h04);
      check("liu_clr", {7'h0, irq_n_oe}, 8'h00);
      wr(A_BERT_MASK, 8'h07);
      pulse(12'h008);
      check("irq_bert", {7'h0, irq_n_oe}, 8'h01);
      wr(A_GMASK, 8'h04);
      check("irq_bglob", {7'h0, irq_n_oe}, 8'h00);
      rd(A_INT_SUM);
      check("sum_bert", q, 8'h04);
      rd(A_BERT_STAT);
      check("bert_stat", q, 8'h08);
      wr(A_GMASK, 8'h00);
      check("irq_bback", {7'h0, irq_n_oe}, 8'h01);
      serial_mode = 1'b1;
      serial_sdo = 1'b1;
      serial_sdo_oe = 1'b1;
      @(negedge mclk);
      check("sdo_oe", data_oe, 8'h01);
      check("sdo_hi", {7'h0, data_out[0]}, 8'h01);
      serial_sdo = 1'b0;
      @(negedge mclk);
      check("sdo_lo", {7'h0, data_out[0]}, 8'h00);
      serial_mode = 1'b0;
      rst = 1'b1;
      repeat (2) @(negedge mclk);
      rst = 1'b0;
      check("oe_rst2", data_oe, 8'h00);
      check("irq_rst2", {7'h0, irq_n_oe}, 8'h00);
      rd(A_FR_STAT);
      check("stat_rst2", q, 8'h00);
      rd(A_GMASK);
      check("gmask_rst2", q, 8'hff);
      rd(4'h8);
      check("scr_rst2", q, 8'h00);
      finish_test();
   end
endmodule : hrap_port_test
